// ===== rtl/psrsp_pkg.sv
package psrsp_pkg;
	localparam int DATA_W = 8;
	localparam int CA_BYTES = 6;
	localparam int LAT_CLOCKS = 4;
	localparam int CLK_HZ = 20000000;
	localparam int CSM_IND_NS = 4000;
	localparam int CSM_EXT_NS = 1000;
	localparam int CSM_IND_CYC = (CSM_IND_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int CSM_EXT_CYC = (CSM_EXT_NS * (CLK_HZ / 1000000)) / 1000;

	typedef enum logic [2:0] {
		PSRSP_IDLE = 3'b000,
		PSRSP_CA   = 3'b001,
		PSRSP_LAT  = 3'b010,
		PSRSP_RD   = 3'b011,
		PSRSP_WR   = 3'b100
	} psrsp_state_t;

	typedef struct packed {
		logic       oe_n;
		logic       val;
	} psrsp_strobe_t;

	typedef struct packed {
		logic               oe_n;
		logic [DATA_W-1:0]  val;
	} psrsp_dq_t;

	typedef struct packed {
		logic               valid;
		logic               masked;
		logic [DATA_W-1:0]  data;
	} psrsp_wbyte_t;
endpackage

// ===== rtl/psrsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser; first stage feeds only the second
module psrsp_sync #(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_in,
	input  wire logic         sys_rst_in,
	input  wire logic [W-1:0] d_in,
	output var  logic [W-1:0] q_out
);
	logic [W-1:0] meta_reg;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			meta_reg <= RST_VAL;
			q_out    <= RST_VAL;
		end else begin
			meta_reg <= d_in;
			q_out    <= meta_reg;
		end
	end
endmodule
`default_nettype wire

// ===== rtl/psrsp_port.sv
`timescale 1ns/1ps
`default_nettype none
module psrsp_port
	import psrsp_pkg::*;
(
	input  wire logic                             clk_in,
	input  wire logic                             sys_rst_in,
	input  wire logic                             cs_n_in,
	input  wire logic                             hw_reset_n_in,
	input  wire logic                             bus_clock_in,
	input  wire logic                             shifted_clock_in,
	input  wire logic                             centre_aligned_strobe_option_in,
	input  wire logic                             extra_latency_in,
	input  wire logic [psrsp_pkg::DATA_W-1:0]     dq_in,
	input  wire logic                             rw_strobe_in,
	input  wire logic [psrsp_pkg::DATA_W-1:0]     rd_data_in,
	output var  logic [psrsp_pkg::DATA_W-1:0]     dq_out,
	output var  logic                             dq_oe_n_out,
	output var  logic                             rw_strobe_out,
	output var  logic                             rw_strobe_oe_n_out,
	output var  logic [8*psrsp_pkg::CA_BYTES-1:0] ca_out,
	output var  logic                             ca_valid_out,
	output var  psrsp_pkg::psrsp_wbyte_t          wbyte_out,
	output var  logic                             rd_req_out,
	output var  logic                             cs_overrun_out
);
	import psrsp_pkg::*;

	logic [DATA_W+5:0] s_q;
	logic              cs_n_s, rst_n_s, ck_s, psc_s, rw_strobe_s, opt_s;
	logic [DATA_W-1:0] dq_s;
	logic              cs_n_d_reg, ck_d_reg, psc_d_reg;
	psrsp_state_t      state_reg;
	logic [2:0]        byte_cnt_reg;
	logic [3:0]        lat_cnt_reg;
	logic              is_read_reg, lat2_reg;
	logic [12:0]       csm_cnt_reg;

	// resets to the idle levels of chip select and hardware reset: no false edge after reset
	psrsp_sync #(
		.W       (DATA_W + 6),
		.RST_VAL ({2'b11, {(DATA_W + 4){1'b0}}})
	) u_sync (
		.clk_in     (clk_in),
		.sys_rst_in (sys_rst_in),
		.d_in       ({cs_n_in, hw_reset_n_in, bus_clock_in, shifted_clock_in,
		              rw_strobe_in, centre_aligned_strobe_option_in, dq_in}),
		.q_out      (s_q)
	);
	assign {cs_n_s, rst_n_s, ck_s, psc_s, rw_strobe_s, opt_s} = s_q[DATA_W+5:DATA_W];
	assign dq_s = s_q[DATA_W-1:0];

	function automatic logic edge_any(input logic now, input logic was);
		return now ^ was;
	endfunction

	wire cs_fall = cs_n_d_reg & ~cs_n_s;
	wire cs_rise = ~cs_n_d_reg & cs_n_s;
	wire ck_edge = edge_any(ck_s, ck_d_reg);
	// option selects which clock times the read strobe
	wire rd_ref  = opt_s ? psc_s : ck_s;
	wire rd_refd = opt_s ? psc_d_reg : ck_d_reg;
	wire rd_edge = edge_any(rd_ref, rd_refd);
	wire active  = rst_n_s & ~cs_n_s;

	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			cs_n_d_reg <= 1'b1;
			ck_d_reg   <= 1'b0;
			psc_d_reg  <= 1'b0;
		end else begin
			cs_n_d_reg <= cs_n_s;
			ck_d_reg   <= ck_s;
			psc_d_reg  <= psc_s;
		end
	end

	// transaction sequencer
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !rst_n_s || cs_n_s) begin
			state_reg    <= PSRSP_IDLE;
			byte_cnt_reg <= 3'h0;
			lat_cnt_reg  <= 4'h0;
			is_read_reg  <= 1'b0;
			lat2_reg     <= 1'b0;
			ca_out       <= '0;
			ca_valid_out <= 1'b0;
		end else begin
			ca_valid_out <= 1'b0;
			unique case (state_reg)
				PSRSP_IDLE: if (cs_fall) begin
					state_reg    <= PSRSP_CA;
					lat2_reg     <= extra_latency_in;
					byte_cnt_reg <= 3'h0;
				end
				PSRSP_CA: if (ck_edge) begin
					ca_out <= {ca_out[8*CA_BYTES-9:0], dq_s};
					byte_cnt_reg <= byte_cnt_reg + 3'h1;
					if (byte_cnt_reg == 3'(CA_BYTES - 1)) begin
						state_reg    <= PSRSP_LAT;
						ca_valid_out <= 1'b1;
						is_read_reg  <= ca_out[8*CA_BYTES-9];
						lat_cnt_reg  <= lat2_reg ? 4'(4*LAT_CLOCKS-1) : 4'(2*LAT_CLOCKS-1);
					end
				end
				PSRSP_LAT: if (ck_edge) begin
					if (lat_cnt_reg == 4'h0)
						state_reg <= is_read_reg ? PSRSP_RD : PSRSP_WR;
					else
						lat_cnt_reg <= lat_cnt_reg - 4'h1;
				end
				PSRSP_RD, PSRSP_WR: state_reg <= state_reg;
				default: state_reg <= PSRSP_IDLE;
			endcase
		end
	end

	// read data and strobe drive
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !rst_n_s) begin
			dq_oe_n_out        <= 1'b1;
			rw_strobe_oe_n_out <= 1'b1;
			dq_out             <= '0;
			rw_strobe_out      <= 1'b0;
			rd_req_out         <= 1'b0;
		end else begin
			rd_req_out <= 1'b0;
			if (!active || state_reg == PSRSP_WR) begin
				dq_oe_n_out        <= 1'b1;
				rw_strobe_oe_n_out <= 1'b1;
			end else if (state_reg == PSRSP_RD) begin
				dq_oe_n_out        <= 1'b0;
				rw_strobe_oe_n_out <= 1'b0;
				if (ck_edge) begin
					dq_out     <= rd_data_in;
					rd_req_out <= 1'b1;
				end
				if (rd_edge)
					rw_strobe_out <= ~rw_strobe_out;
			end else begin
				dq_oe_n_out        <= 1'b1;
				rw_strobe_oe_n_out <= 1'b0;
				rw_strobe_out      <= (state_reg == PSRSP_IDLE) ? extra_latency_in : lat2_reg;
			end
		end
	end

	// write bytes, strobe taken as mask; shifted clock not consulted
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || !rst_n_s) begin
			wbyte_out <= '0;
		end else begin
			wbyte_out.valid  <= active && state_reg == PSRSP_WR && ck_edge;
			wbyte_out.masked <= rw_strobe_s;
			wbyte_out.data   <= dq_s;
		end
	end

	// flags the host overrunning the low-time limit; the device cannot enforce it
	always_ff @(posedge clk_in) begin
		if (sys_rst_in || cs_n_s) begin
			csm_cnt_reg    <= 13'h0;
			cs_overrun_out <= 1'b0;
		end else begin
			if (csm_cnt_reg != 13'h1FFF)
				csm_cnt_reg <= csm_cnt_reg + 13'h1;
			if (csm_cnt_reg >= 13'(CSM_IND_CYC))
				cs_overrun_out <= 1'b1;
		end
	end

	property p_reset_release;
		@(posedge clk_in) disable iff (sys_rst_in) !rst_n_s |=> dq_oe_n_out && rw_strobe_oe_n_out;
	endproperty
	a_reset_release: assert property (p_reset_release) else $error("lines not released");

	property p_idle_reset;
		@(posedge clk_in) disable iff (sys_rst_in) !rst_n_s |=> state_reg == PSRSP_IDLE;
	endproperty
	a_idle_reset: assert property (p_idle_reset) else $error("not idle after reset");

	property p_cs_end;
		@(posedge clk_in) disable iff (sys_rst_in) cs_n_s |=> state_reg == PSRSP_IDLE;
	endproperty
	a_cs_end: assert property (p_cs_end) else $error("transaction survived chip select high");

	property p_start;
		@(posedge clk_in) disable iff (sys_rst_in)
			rst_n_s && state_reg == PSRSP_IDLE && cs_fall |=> state_reg == PSRSP_CA;
	endproperty
	a_start: assert property (p_start) else $error("no start on chip select fall");

	property p_lat_flag;
		@(posedge clk_in) disable iff (sys_rst_in)
			rst_n_s && active && state_reg == PSRSP_LAT |=> rw_strobe_out == $past(lat2_reg) || !active;
	endproperty
	a_lat_flag: assert property (p_lat_flag) else $error("latency indication wrong");

	property p_wr_input;
		@(posedge clk_in) disable iff (sys_rst_in)
			state_reg == PSRSP_WR |=> rw_strobe_oe_n_out && dq_oe_n_out;
	endproperty
	a_wr_input: assert property (p_wr_input) else $error("strobe driven during write");

	property p_rd_strobe;
		@(posedge clk_in) disable iff (sys_rst_in)
			rst_n_s && active && state_reg == PSRSP_RD && !rd_edge ##1 rst_n_s
			|-> $stable(rw_strobe_out);
	endproperty
	a_rd_strobe: assert property (p_rd_strobe) else $error("strobe moved off reference edge");

	property p_wr_mask;
		@(posedge clk_in) disable iff (sys_rst_in)
			rst_n_s && wbyte_out.valid |-> wbyte_out.masked == $past(rw_strobe_s);
	endproperty
	a_wr_mask: assert property (p_wr_mask) else $error("mask not sampled");

	property p_overrun;
		@(posedge clk_in) disable iff (sys_rst_in) cs_n_s |=> !cs_overrun_out;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun flag stuck");

	c_read: cover property (@(posedge clk_in) state_reg == PSRSP_RD && rd_edge);
	c_write: cover property (@(posedge clk_in) wbyte_out.valid);
	c_extra: cover property (@(posedge clk_in) state_reg == PSRSP_LAT && lat2_reg);
endmodule
`default_nettype wire

// ===== dv/psrsp_host.sv
`timescale 1ns/1ps
`default_nettype none
// host model; single-ended clocks, no complement lines
module psrsp_host (
	input  wire logic       clk_in,
	output var  logic       cs_n_out,
	output var  logic       ck_out,
	output var  logic       psc_out,
	output var  logic [7:0] dq_out,
	output var  logic       dq_oe_out,
	output var  logic       ds_out,
	output var  logic       ds_oe_out
);
	initial begin
		{cs_n_out, ck_out, psc_out} = 3'h4;
		{dq_out, dq_oe_out, ds_out, ds_oe_out} = 11'h000;
	end
	task automatic wait_cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic open_tx();
		ck_out = 1'b0;
		cs_n_out = 1'b0;
		wait_cyc(4);
	endtask
	// data set one cycle ahead of the bus clock edge for setup
	task automatic ck_step(input logic [7:0] d, input logic m, input logic dq_drv,
		input logic ds_drv, input logic run_psc);
		dq_out = d;
		dq_oe_out = dq_drv;
		ds_out = m;
		ds_oe_out = ds_drv;
		wait_cyc(1);
		ck_out = ~ck_out;
		wait_cyc(2);
		// quarter period late; held low in writes
		if (run_psc) begin
			psc_out = ~psc_out;
		end
		wait_cyc(1);
	endtask
	task automatic close_tx();
		{cs_n_out, dq_oe_out, ds_oe_out} = 3'h4;
		wait_cyc(6);
	endtask
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import psrsp_pkg::*;
	logic        clk_in, sys_rst_in, hw_n, opt, extra, tog, ds_last;
	logic        cs_n, ck, shifted_clock, h_dq_oe, h_ds, h_ds_oe, ds_w, ds_o;
	logic        dq_oe_n, ds_oe_n, ca_valid, rd_req, overrun;
	logic [7:0]  h_dq, dq_w, rd_data, dq_o;
	logic [47:0] ca;
	psrsp_wbyte_t wb;
	psrsp_wbyte_t wq[$];
	int          mismatches, compares, n_ca, n_rd, n_tg;
	// released lines show a changing pattern, never a stale value
	assign dq_w = !dq_oe_n ? dq_o : h_dq_oe ? h_dq : {8{tog}};
	assign ds_w = !ds_oe_n ? ds_o : h_ds_oe ? h_ds : tog;
	psrsp_host host (.clk_in(clk_in), .cs_n_out(cs_n), .ck_out(ck), .psc_out(shifted_clock),
		.dq_out(h_dq), .dq_oe_out(h_dq_oe), .ds_out(h_ds), .ds_oe_out(h_ds_oe));
	psrsp_port DUT (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .cs_n_in(cs_n),
		.hw_reset_n_in(hw_n), .bus_clock_in(ck), .shifted_clock_in(shifted_clock),
		.centre_aligned_strobe_option_in(opt), .extra_latency_in(extra),
		.dq_in(dq_w), .rw_strobe_in(ds_w), .rd_data_in(rd_data), .dq_out(dq_o),
		.dq_oe_n_out(dq_oe_n), .rw_strobe_out(ds_o), .rw_strobe_oe_n_out(ds_oe_n),
		.ca_out(ca), .ca_valid_out(ca_valid), .wbyte_out(wb), .rd_req_out(rd_req),
		.cs_overrun_out(overrun));
	initial begin
		clk_in = 1'b0;
		forever #25 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		tog <= ~tog;
		ds_last <= ds_o;
		if (ca_valid === 1'b1) n_ca <= n_ca + 1;
		if (rd_req === 1'b1) n_rd <= n_rd + 1;
		if (wb.valid === 1'b1) wq.push_back(wb);
		if (dq_oe_n === 1'b0 && ds_oe_n === 1'b0 && ds_o !== ds_last) n_tg <= n_tg + 1;
	end
	task automatic check(input logic [47:0] got, input logic [47:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("compares=%0d mismatches=%0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic send_ca(input logic [47:0] c, input int lat);
		n_ca = 0;
		host.open_tx();
		check(ds_oe_n, 0);
		check(ds_o, extra);
		for (int i = 5; i >= 0; i--) host.ck_step(c[i*8 +: 8], 1'b0, 1'b1, 1'b0, 1'b0);
		repeat (lat) host.ck_step(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
		check(48'(n_ca), 1);
		check(ca, c);
	endtask
	task automatic t_write(input logic x);
		extra = x;
		wq.delete();
		send_ca(48'h0012_3456_789A, 2 * LAT_CLOCKS * (x ? 2 : 1));
		for (int i = 0; i < 4; i++) host.ck_step(8'((i + 1) * 17), i[0], 1'b1, 1'b1, 1'b0);
		host.wait_cyc(4);
		check(ds_oe_n, 1);
		check(48'(wq.size()), 4);
		for (int i = 0; i < wq.size(); i++) begin
			check({wq[i].masked, wq[i].data}, {i[0], 8'((i + 1) * 17)});
		end
		host.close_tx();
		$display("write test done");
	endtask
	task automatic t_read(input logic o, input logic run);
		{opt, extra, rd_data, n_rd, n_tg} = {o, 1'b0, 8'h5C, 64'h0};
		send_ca(48'h8000_0000_0010, 2 * LAT_CLOCKS);
		repeat (6) host.ck_step(8'h00, 1'b0, 1'b0, 1'b0, run);
		check(dq_oe_n, 0);
		check(dq_o, 8'h5C);
		check(n_rd != 0, 1);
		check(n_tg != 0, {run | ~o});
		host.close_tx();
		check({dq_oe_n, ds_oe_n}, 3);
		$display("read test done");
	endtask
	task automatic t_hwreset();
		{opt, extra} = 2'h0;
		send_ca(48'h8000_0000_0020, 2 * LAT_CLOCKS);
		repeat (2) host.ck_step(8'h00, 1'b0, 1'b0, 1'b0, 1'b0);
		hw_n = 1'b0;
		host.wait_cyc(4);
		check({dq_oe_n, ds_oe_n}, 3);
		hw_n = 1'b1;
		host.close_tx();
		$display("hw reset test done");
	endtask
	task automatic t_overrun();
		host.open_tx();
		host.wait_cyc(70);
		check(overrun, 0);
		host.wait_cyc(15);
		check(overrun, 1);
		host.close_tx();
		check(overrun, 0);
		$display("overrun test done");
	endtask
	initial begin
		{sys_rst_in, hw_n, opt, extra, tog, ds_last, rd_data} = 14'h3000;
		{mismatches, compares, n_ca, n_rd, n_tg} = 160'h0;
		repeat (10) @(posedge clk_in);
		@(negedge clk_in);
		sys_rst_in = 1'b0;
		check({dq_oe_n, ds_oe_n, overrun}, 6);
		host.wait_cyc(3);
		t_hwreset();
		for (int x = 0; x < 2; x++) t_write(x[0]);
		t_read(1'b1, 1'b1);
		t_read(1'b1, 1'b0);
		t_read(1'b0, 1'b0);
		t_overrun();
		print_verdict();
	end
	// bounded run: a hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge clk_in);
		mismatches++;
		print_verdict();
	end
endmodule
`default_nettype wire
